// *** logic/clp_defines.svh ***
`ifndef CLP_DEFINES_SVH
`define CLP_DEFINES_SVH
// timing
`define CLP_CLK_NS       50
`define CLP_CYCLE_NS     5000000
`define CLP_CYCLE_CYC    (`CLP_CYCLE_NS / `CLP_CLK_NS)
// reset ratio in percent, applied to the setting
`define CLP_RESET_PCT    7'h61
`define CLP_FULL_PCT     7'h64
// register byte offsets
`define CLP_CTRL_OFS     8'h00
`define CLP_LOW_OFS      8'h04
`define CLP_HIGH_OFS     8'h08
`define CLP_OVER_OFS     8'h0c
`define CLP_STATUS_OFS   8'h10
`define CLP_ISTAT_OFS    8'h14
`define CLP_IMASK_OFS    8'h18
// reset values, thresholds in hundredths of nominal current
`define CLP_CTRL_RST     1'h1
`define CLP_LOW_RST      12'h014
`define CLP_HIGH_RST     12'h078
`define CLP_OVER_RST     12'h0c8
// status field positions
`define CLP_ST_LOW_LSB   0
`define CLP_ST_HIGH_LSB  3
`define CLP_ST_OVER_LSB  6
`define CLP_ST_COND_LSB  9
`define CLP_ST_STATE_LSB 12
// interrupt event bits
`define CLP_EV_ACTIVE    0
`define CLP_EV_BLOCKED   1
`define CLP_EV_OVER      2
`define CLP_EV_HIGH      3
`define CLP_EV_W         4
`endif

// *** logic/clp_pkg.sv ***
package clp_pkg;
  typedef logic [11:0] clp_thr_t;
  typedef logic [15:0] clp_mag_t;
  typedef enum logic [1:0] {
    CLP_IDLE    = 2'b00,
    CLP_ACTIVE  = 2'b01,
    CLP_BLOCKED = 2'b10
  } clp_state_t;
endpackage

// *** logic/clp_irq_if.sv ***
`timescale 1ns/1ns
`include "clp_defines.svh"
interface clp_irq_if;
  logic [`CLP_EV_W-1:0] ev;
  logic                 clr_we;
  logic [`CLP_EV_W-1:0] clr_data;
  logic [`CLP_EV_W-1:0] mask;
  logic [`CLP_EV_W-1:0] stat;
  logic                 irq;
  modport src  (output ev, clr_we, clr_data, mask, input stat, irq);
  modport sink (input ev, clr_we, clr_data, mask, output stat, irq);
endinterface // clp_irq_if

// *** logic/clp_hyst_cmp.sv ***
`timescale 1ns/1ns
`include "clp_defines.svh"
module clp_hyst_cmp (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              tick,
  input  wire clp_pkg::clp_mag_t mag,
  input  wire clp_pkg::clp_thr_t thr,
  output logic                   above_ff
);
  import clp_pkg::*;
  // scaled compare avoids a divider: mag*100 against thr*pct
  function automatic logic below_pct(input clp_mag_t m, input clp_thr_t t,
                                     input logic [6:0] pct);
    logic [22:0] lhs;
    logic [22:0] rhs;
    lhs = 23'(m) * 23'(`CLP_FULL_PCT);
    rhs = 23'(t) * 23'(pct);
    below_pct = lhs < rhs;
  endfunction

  logic pick;
  logic drop;
  assign pick = mag > 16'(thr);
  assign drop = below_pct(mag, thr, `CLP_RESET_PCT);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      above_ff <= 1'b0;
    end else if (ce && tick) begin
      if (above_ff && drop) begin
        above_ff <= 1'b0;
      end else if (!above_ff && pick) begin
        above_ff <= 1'b1;
      end
    end
  end
endmodule // clp_hyst_cmp

// *** logic/clp_irq.sv ***
`timescale 1ns/1ns
`include "clp_defines.svh"
module clp_irq (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic ce,
  clp_irq_if.sink   bus
);
  logic [`CLP_EV_W-1:0] stat_ff;
  logic                 irq_ff;

  // a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_ff <= '0;
    end else if (ce) begin
      stat_ff <= (stat_ff & ~({`CLP_EV_W{bus.clr_we}} & bus.clr_data)) | bus.ev;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else if (ce) begin
      irq_ff <= |(stat_ff & bus.mask);
    end
  end

  assign bus.stat = stat_ff;
  assign bus.irq  = irq_ff;
endmodule // clp_irq

// *** logic/clp_top.sv ***
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "clp_defines.svh"
// What this block does
// - sample three phase magnitudes every 5 ms
// - each phase compared against every threshold
// - drop out below 97 % of setting
// - one threshold shared by all phases
// - each phase picks up independently
// - low condition needs all phases below low
// - high condition needs all phases above high
// - any phase over overcurrent drops pickup now
// - thresholds may change while running
// - unblocked pickup raises cold load active
// - blocked pickup raises blocked indication only
module clp_top #(
  parameter int CYCLE_CNT = `CLP_CYCLE_CYC
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire clp_pkg::clp_mag_t phase_a_fundamental_magnitude,
  input  wire clp_pkg::clp_mag_t phase_b_fundamental_magnitude,
  input  wire clp_pkg::clp_mag_t phase_c_fundamental_magnitude,
  input  wire logic             block_in,
  input  wire logic             release_req,
  output logic                  cold_load_active,
  output logic                  cold_load_blocked,
  output logic                  low_all,
  output logic                  high_all,
  output logic                  over_any,
  output logic                  irq
);
  import clp_pkg::*;

  localparam int CW = $clog2(CYCLE_CNT);

  clp_irq_if irq_bus ();

  // register file
  logic                 ctrl_en_ff;
  clp_thr_t             low_current_threshold_ff;
  clp_thr_t             high_current_threshold_ff;
  clp_thr_t             overcurrent_threshold_ff;
  logic [`CLP_EV_W-1:0] imask_ff;
  logic [31:0]          prdata_ff;
  logic                 pready_ff;
  logic                 pslverr_ff;

  // cycle strobe and evaluation
  logic [CW-1:0]        cnt_ff;
  logic                 tick_ff;
  logic                 eval_ff;
  logic                 low_prev_ff;
  clp_state_t           state_ff;
  clp_state_t           nxt_state;
  logic                 active_ff;
  logic                 blocked_ff;
  logic                 low_all_ff;
  logic                 high_all_ff;
  logic                 over_any_ff;
  logic [`CLP_EV_W-1:0] ev;

  clp_mag_t             measured_magnitude [3];
  clp_thr_t             thr_sel [3];
  logic [2:0]           above_low;
  logic [2:0]           above_high;
  logic [2:0]           above_over;
  logic                 low_cond;
  logic                 high_cond;
  logic                 over_cond;
  logic                 pickup;
  logic                 wr_acc;
  logic                 rd_acc;
  logic                 addr_ok;
  logic [31:0]          status;

  assign measured_magnitude[0] = phase_a_fundamental_magnitude;
  assign measured_magnitude[1] = phase_b_fundamental_magnitude;
  assign measured_magnitude[2] = phase_c_fundamental_magnitude;
  assign thr_sel[0] = low_current_threshold_ff;
  assign thr_sel[1] = high_current_threshold_ff;
  assign thr_sel[2] = overcurrent_threshold_ff;

  // strobe generator; stopping it freezes every comparator and the state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else if (ce) begin
      tick_ff <= 1'b0;
      if (!ctrl_en_ff) begin
        cnt_ff <= '0;
      end else if (cnt_ff == CW'(CYCLE_CNT - 1)) begin
        cnt_ff  <= '0;
        tick_ff <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  // evaluation waits one cycle so every flag reflects the same sample set
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      eval_ff <= 1'b0;
    end else if (ce) begin
      eval_ff <= tick_ff;
    end
  end

  genvar gp;
  genvar gs;
  generate
    for (gp = 0; gp < 3; gp++) begin : g_phase
      for (gs = 0; gs < 3; gs++) begin : g_set
        logic flag;
        clp_hyst_cmp u_cmp (
          .sys_clk  (sys_clk),
          .rst      (rst),
          .ce       (ce),
          .tick     (tick_ff),
          .mag      (measured_magnitude[gp]),
          .thr      (thr_sel[gs]),
          .above_ff (flag)
        );
      end
      assign above_low[gp]  = g_set[0].flag;
      assign above_high[gp] = g_set[1].flag;
      assign above_over[gp] = g_set[2].flag;
    end
  endgenerate

  assign low_cond  = ~|above_low;
  assign high_cond = &above_high;
  assign over_cond = |above_over;
  assign pickup    = low_cond && !low_prev_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      low_all_ff  <= 1'b0;
      high_all_ff <= 1'b0;
      over_any_ff <= 1'b0;
      low_prev_ff <= 1'b0;
    end else if (ce && eval_ff) begin
      low_all_ff  <= low_cond;
      high_all_ff <= high_cond;
      over_any_ff <= over_cond;
      low_prev_ff <= low_cond;
    end
  end

  // a block arriving after activation resets the active output
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CLP_IDLE: begin
        if (pickup) begin
          nxt_state = block_in ? CLP_BLOCKED : CLP_ACTIVE;
        end
      end
      CLP_ACTIVE: begin
        if (over_cond || block_in || release_req) begin
          nxt_state = CLP_IDLE;
        end
      end
      CLP_BLOCKED: begin
        if (!low_cond) begin
          nxt_state = CLP_IDLE;
        end
      end
      default: nxt_state = CLP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff   <= CLP_IDLE;
      active_ff  <= 1'b0;
      blocked_ff <= 1'b0;
    end else if (ce && eval_ff) begin
      state_ff   <= nxt_state;
      active_ff  <= nxt_state == CLP_ACTIVE;
      blocked_ff <= nxt_state == CLP_BLOCKED;
    end
  end

  always_comb begin
    ev = '0;
    if (eval_ff) begin
      ev[`CLP_EV_ACTIVE]  = state_ff == CLP_IDLE && nxt_state == CLP_ACTIVE;
      ev[`CLP_EV_BLOCKED] = state_ff == CLP_IDLE && nxt_state == CLP_BLOCKED;
      ev[`CLP_EV_OVER]    = state_ff == CLP_ACTIVE && over_cond;
      ev[`CLP_EV_HIGH]    = high_cond && !high_all_ff;
    end
  end

  // apb slave: no wait states, data and error registered with pready
  assign wr_acc = psel && penable && pready_ff && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign addr_ok = paddr == `CLP_CTRL_OFS || paddr == `CLP_LOW_OFS ||
                   paddr == `CLP_HIGH_OFS || paddr == `CLP_OVER_OFS ||
                   paddr == `CLP_STATUS_OFS || paddr == `CLP_ISTAT_OFS ||
                   paddr == `CLP_IMASK_OFS;
  assign status = {16'h0000, blocked_ff, active_ff, state_ff, over_any_ff,
                   high_all_ff, low_all_ff, above_over, above_high, above_low};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (ce) begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && !addr_ok;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prdata_ff <= '0;
    end else if (ce && rd_acc) begin
      if (paddr == `CLP_CTRL_OFS) begin
        prdata_ff <= {31'h0, ctrl_en_ff};
      end else if (paddr == `CLP_LOW_OFS) begin
        prdata_ff <= {20'h0, low_current_threshold_ff};
      end else if (paddr == `CLP_HIGH_OFS) begin
        prdata_ff <= {20'h0, high_current_threshold_ff};
      end else if (paddr == `CLP_OVER_OFS) begin
        prdata_ff <= {20'h0, overcurrent_threshold_ff};
      end else if (paddr == `CLP_STATUS_OFS) begin
        prdata_ff <= status;
      end else if (paddr == `CLP_ISTAT_OFS) begin
        prdata_ff <= {28'h0, irq_bus.stat};
      end else if (paddr == `CLP_IMASK_OFS) begin
        prdata_ff <= {28'h0, imask_ff};
      end else begin
        prdata_ff <= '0;
      end
    end
  end

  // new settings apply from the next strobe, no stop needed
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_en_ff                <= `CLP_CTRL_RST;
      low_current_threshold_ff  <= `CLP_LOW_RST;
      high_current_threshold_ff <= `CLP_HIGH_RST;
      overcurrent_threshold_ff  <= `CLP_OVER_RST;
      imask_ff                  <= '0;
    end else if (ce && wr_acc) begin
      if (paddr == `CLP_CTRL_OFS) begin
        ctrl_en_ff <= pwdata[0];
      end else if (paddr == `CLP_LOW_OFS) begin
        low_current_threshold_ff <= pwdata[11:0];
      end else if (paddr == `CLP_HIGH_OFS) begin
        high_current_threshold_ff <= pwdata[11:0];
      end else if (paddr == `CLP_OVER_OFS) begin
        overcurrent_threshold_ff <= pwdata[11:0];
      end else if (paddr == `CLP_IMASK_OFS) begin
        imask_ff <= pwdata[`CLP_EV_W-1:0];
      end
    end
  end

  assign irq_bus.ev       = ev;
  assign irq_bus.clr_we   = wr_acc && paddr == `CLP_ISTAT_OFS;
  assign irq_bus.clr_data = pwdata[`CLP_EV_W-1:0];
  assign irq_bus.mask     = imask_ff;

  clp_irq u_irq (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .bus     (irq_bus)
  );

  assign prdata            = prdata_ff;
  assign pready            = pready_ff;
  assign pslverr           = pslverr_ff;
  assign cold_load_active  = active_ff;
  assign cold_load_blocked = blocked_ff;
  assign low_all           = low_all_ff;
  assign high_all          = high_all_ff;
  assign over_any          = over_any_ff;
  assign irq               = irq_bus.irq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  int cyc_last;
  assign cyc_last = CYCLE_CNT - 1;

  sequence s_wr_low;
    ce && psel && penable && pready_ff && pwrite && paddr == `CLP_LOW_OFS;
  endsequence

  sequence s_idle_pickup;
    ce && eval_ff && state_ff == CLP_IDLE && pickup;
  endsequence

  property p_tick_period;
    ce && tick_ff && $past(ce) |-> $past(cnt_ff) == cyc_last[CW-1:0];
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("strobe off period");

  property p_eval_follows;
    ce && tick_ff |=> eval_ff;
  endproperty
  a_eval_follows: assert property (p_eval_follows) else $error("no evaluation");

  property p_low_all;
    ce && eval_ff |=> low_all_ff == ~|$past(above_low);
  endproperty
  a_low_all: assert property (p_low_all) else $error("low condition wrong");

  property p_high_all;
    ce && eval_ff |=> high_all_ff == &$past(above_high);
  endproperty
  a_high_all: assert property (p_high_all) else $error("high condition wrong");

  property p_over_drop;
    ce && eval_ff && state_ff == CLP_ACTIVE && over_cond |=> !active_ff;
  endproperty
  a_over_drop: assert property (p_over_drop) else $error("overcurrent kept pickup");

  property p_active;
    s_idle_pickup ##0 !block_in |=> active_ff && !blocked_ff;
  endproperty
  a_active: assert property (p_active) else $error("pickup not activated");

  property p_blocked;
    s_idle_pickup ##0 block_in |=> blocked_ff && !active_ff;
  endproperty
  a_blocked: assert property (p_blocked) else $error("blocked pickup activated");

  property p_thr_write;
    s_wr_low |=> low_current_threshold_ff == $past(pwdata[11:0]);
  endproperty
  a_thr_write: assert property (p_thr_write) else $error("threshold write lost");

  property p_hyst_hold;
    ce && tick_ff && above_over[0] &&
      24'(phase_a_fundamental_magnitude) * 24'd100 >=
      24'(overcurrent_threshold_ff) * 24'd97 |=> above_over[0];
  endproperty
  a_hyst_hold: assert property (p_hyst_hold) else $error("dropped above reset level");

  property p_phase_pick;
    ce && tick_ff && phase_c_fundamental_magnitude > 16'(overcurrent_threshold_ff)
      |=> above_over[2];
  endproperty
  a_phase_pick: assert property (p_phase_pick) else $error("phase did not pick up");
endmodule // clp_top

// *** testbench/clp_meas_model.sv ***
`timescale 1ns/1ns
module clp_meas_model (
  input  wire logic              sys_clk,
  input  wire clp_pkg::clp_mag_t req_a,
  input  wire clp_pkg::clp_mag_t req_b,
  input  wire clp_pkg::clp_mag_t req_c,
  input  wire logic              req_block,
  input  wire logic              req_release,
  output clp_pkg::clp_mag_t      phase_a_fundamental_magnitude,
  output clp_pkg::clp_mag_t      phase_b_fundamental_magnitude,
  output clp_pkg::clp_mag_t      phase_c_fundamental_magnitude,
  output logic                   block_in,
  output logic                   release_req
);
  import clp_pkg::*;
  // front end refreshes every clock; the block alone picks its sampling instant
  always_ff @(posedge sys_clk) begin
    phase_a_fundamental_magnitude <= req_a;
    phase_b_fundamental_magnitude <= req_b;
    phase_c_fundamental_magnitude <= req_c;
  end
  // timer side: plain levels, no synchroniser needed in one clock domain
  always_ff @(posedge sys_clk) begin
    block_in    <= req_block;
    release_req <= req_release;
  end
endmodule // clp_meas_model

// *** testbench/testbench.sv ***
`timescale 1ns/1ns
`include "clp_defines.svh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin bad_count++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module testbench;
  import clp_pkg::*;
  localparam int CYC = 10;
  logic        sys_clk, rst, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  clp_mag_t    req_a, req_b, req_c, mag_a, mag_b, mag_c;
  logic        block_req, rel_req, block_in, release_req;
  logic        act, blk, low_all, high_all, over_any, irq;
  int          bad_count, samples_checked, cyc_count;

  clp_top #(.CYCLE_CNT(CYC)) clp_top_i (.sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .phase_a_fundamental_magnitude(mag_a),
    .phase_b_fundamental_magnitude(mag_b), .phase_c_fundamental_magnitude(mag_c),
    .block_in(block_in), .release_req(release_req), .cold_load_active(act),
    .cold_load_blocked(blk), .low_all(low_all), .high_all(high_all), .over_any(over_any),
    .irq(irq));
  clp_meas_model clp_meas_model_i (.sys_clk(sys_clk), .req_a(req_a), .req_b(req_b),
    .req_c(req_c), .req_block(block_req), .req_release(rel_req),
    .phase_a_fundamental_magnitude(mag_a), .phase_b_fundamental_magnitude(mag_b),
    .phase_c_fundamental_magnitude(mag_c), .block_in(block_in), .release_req(release_req));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // generous ceiling: whole sequence needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc_count++;
    if (cyc_count == 4000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // two full strobe periods guarantee one evaluation on the new samples
  task automatic step(input clp_mag_t a, input clp_mag_t b, input clp_mag_t c);
    @(posedge sys_clk);
    req_a <= a;
    req_b <= b;
    req_c <= c;
    repeat (2 * CYC + 4) @(posedge sys_clk);
  endtask

  task automatic park();
    @(posedge sys_clk);
    rel_req <= 1'b1;
    step(16'h0050, 16'h0050, 16'h0050);
    @(posedge sys_clk);
    rel_req <= 1'b0;
    `CHK("active parked", 1'b0, act)
    apb(1'b1, `CLP_ISTAT_OFS, 32'h0000000f);
  endtask

  task automatic t_regs();
    apb(1'b0, `CLP_CTRL_OFS, 32'h0);
    `CHK("ctrl", 32'h00000001, rd)
    apb(1'b0, `CLP_LOW_OFS, 32'h0);
    `CHK("low thr", 32'h00000014, rd)
    apb(1'b0, `CLP_HIGH_OFS, 32'h0);
    `CHK("high thr", 32'h00000078, rd)
    apb(1'b0, `CLP_OVER_OFS, 32'h0);
    `CHK("over thr", 32'h000000c8, rd)
    apb(1'b0, `CLP_IMASK_OFS, 32'h0);
    `CHK("mask", 32'h00000000, rd)
    apb(1'b0, 8'h1c, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h00000000, rd)
  endtask

  task automatic t_active_irq();
    apb(1'b1, `CLP_IMASK_OFS, 32'h00000001);
    apb(1'b1, `CLP_ISTAT_OFS, 32'h0000000f);
    step(16'h0010, 16'h0010, 16'h0010);
    `CHK("low_all", 1'b1, low_all)
    `CHK("active", 1'b1, act)
    `CHK("irq up", 1'b1, irq)
    apb(1'b0, `CLP_ISTAT_OFS, 32'h0);
    `CHK("ev active", 1'b1, rd[`CLP_EV_ACTIVE])
    apb(1'b1, `CLP_ISTAT_OFS, 32'h00000001);
    repeat (3) @(posedge sys_clk);
    `CHK("irq cleared", 1'b0, irq)
    park();
  endtask

  task automatic t_hyst();
    step(16'h0015, 16'h0010, 16'h0010);
    `CHK("one above low", 1'b0, low_all)
    step(16'h0014, 16'h0010, 16'h0010);
    `CHK("inside band", 1'b0, low_all)
    step(16'h0013, 16'h0010, 16'h0010);
    `CHK("below band", 1'b1, low_all)
    park();
  endtask

  task automatic t_high();
    step(16'h0079, 16'h0079, 16'h0078);
    `CHK("two high", 1'b0, high_all)
    step(16'h0079, 16'h0079, 16'h0079);
    `CHK("three high", 1'b1, high_all)
    `CHK("no over", 1'b0, over_any)
    apb(1'b0, `CLP_STATUS_OFS, 32'h0);
    `CHK("high flags", 3'h7, rd[5:3])
    apb(1'b0, `CLP_ISTAT_OFS, 32'h0);
    `CHK("ev high", 1'b1, rd[`CLP_EV_HIGH])
    park();
  endtask

  task automatic t_over();
    step(16'h0010, 16'h0010, 16'h0010);
    `CHK("active pre", 1'b1, act)
    step(16'h00c9, 16'h0050, 16'h0050);
    `CHK("over_any", 1'b1, over_any)
    `CHK("dropped", 1'b0, act)
    apb(1'b0, `CLP_STATUS_OFS, 32'h0);
    `CHK("over flags", 3'h1, rd[8:6])
    apb(1'b0, `CLP_ISTAT_OFS, 32'h0);
    `CHK("ev over", 1'b1, rd[`CLP_EV_OVER])
    park();
  endtask

  task automatic t_block();
    @(posedge sys_clk);
    block_req <= 1'b1;
    step(16'h0010, 16'h0010, 16'h0010);
    `CHK("blocked", 1'b1, blk)
    `CHK("not active", 1'b0, act)
    `CHK("masked irq", 1'b0, irq)
    apb(1'b0, `CLP_ISTAT_OFS, 32'h0);
    `CHK("ev blocked", 1'b1, rd[`CLP_EV_BLOCKED])
    @(posedge sys_clk);
    block_req <= 1'b0;
    step(16'h0050, 16'h0050, 16'h0050);
    `CHK("unblocked", 1'b0, blk)
    apb(1'b1, `CLP_ISTAT_OFS, 32'h0000000f);
  endtask

  task automatic t_thr_change();
    apb(1'b1, `CLP_LOW_OFS, 32'h00000040);
    apb(1'b0, `CLP_LOW_OFS, 32'h0);
    `CHK("low rewritten", 32'h00000040, rd)
    step(16'h0030, 16'h0030, 16'h0030);
    `CHK("new low", 1'b1, low_all)
    apb(1'b1, `CLP_LOW_OFS, 32'h00000014);
    park();
  endtask

  // stopped strobe, then clock enable low: flags must not follow the new samples
  task automatic t_freeze();
    apb(1'b1, `CLP_CTRL_OFS, 32'h0);
    step(16'h0010, 16'h0010, 16'h0010);
    `CHK("stopped low", 1'b0, low_all)
    apb(1'b1, `CLP_CTRL_OFS, 32'h00000001);
    @(posedge sys_clk);
    ce <= 1'b0;
    repeat (2 * CYC + 4) @(posedge sys_clk);
    `CHK("frozen low", 1'b0, low_all)
    `CHK("frozen active", 1'b0, act)
    ce <= 1'b1;
    repeat (2 * CYC + 4) @(posedge sys_clk);
    `CHK("thawed low", 1'b1, low_all)
    `CHK("thawed active", 1'b1, act)
    park();
  endtask

  initial begin
    rst       = 1'b1;
    ce        = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    req_a     = 16'h0050;
    req_b     = 16'h0050;
    req_c     = 16'h0050;
    block_req = 1'b0;
    rel_req   = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_active_irq();
    t_hyst();
    t_high();
    t_over();
    t_block();
    t_thr_change();
    t_freeze();
    complete_run();
  end
endmodule // testbench
